// *** shared/sotc_defs.vh ***
`ifndef SOTC_DEFS_VH
`define SOTC_DEFS_VH
`define SOTC_OFF_STATUS     6'h00
`define SOTC_OFF_CONTROL    6'h04
`define SOTC_OFF_CEILING    6'h08
`define SOTC_OFF_FLOOR      6'h0C
`define SOTC_OFF_TRIM       6'h10
`define SOTC_OFF_SLOW_TGT   6'h14
`define SOTC_OFF_SLOW_CNT   6'h18
`define SOTC_OFF_REF_TGT    6'h1C
`define SOTC_OFF_REF_CNT    6'h20
`define SOTC_RST_STATUS     8'h00
`define SOTC_RST_CONTROL    8'h00
`define SOTC_RST_CEILING    6'h3F
`define SOTC_RST_FLOOR      6'h00
`define SOTC_RST_TRIM       6'h3F
`define SOTC_RST_SLOW_TGT   3'h0
`define SOTC_RST_REF_TGT    13'h0000
`define SOTC_BIT_CYCLE      0
`define SOTC_BIT_OVF        1
`define SOTC_BIT_CEIL       2
`define SOTC_BIT_FLOOR      3
`define SOTC_BIT_UP         4
`define SOTC_BIT_DOWN       5
`define SOTC_BIT_ENABLE     4
`define SOTC_BIT_TOLERANCE_SELECT     5
`define SOTC_BIT_HOLD       6
`define SOTC_BIT_AUTODIS    7
`define SOTC_TOL_BASE       14'h0010
`define SOTC_TOL_WIDE       14'h0020
`endif

// *** rtl/sotc_calibrator.v ***
// Operation
// - Count reference clocks over the programmed number of slow oscillator periods.
// - At period end compare 13-bit measured count with expected count.
// - Tolerance is 16 counts when select clear, 32 when set.
// - Within tolerance the trim value stays unchanged.
// - Count above expected plus tolerance raises trim by one.
// - Count below expected minus tolerance lowers trim by one.
// - Ceiling is read-only 0x3F; trim above it reverts to ceiling.
// - Floor is a read-write register resetting to zero.
// - Reference oscillator off aborts the cycle, trim untouched.
// - Reading the status register clears only the flags that the read returned.
// - Status bit 5 records a requested decrement even if suppressed.
// - Status bit 4 records a requested increment even if suppressed.
// - Bit 3 sets at floor, bit 2 at ceiling; both interrupt sources.
// - Bit 1 sets on reference counter overflow, an interrupt source.
// - Bit 0 sets at each cycle end; not a full-trim indication.
// - Control bit 4 enables; auto-disable bit 7 clears it at cycle end.
// - Hold bit 6 suppresses stepping at cycle end.
// - Control bits 3..0 enable floor, ceiling, overflow, cycle interrupts.
// - A slow period count of zero disables counting.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sotc_defs.vh"
module sotc_calibrator (
  input  wire        hclk,        // Bus and reference clock
  input  wire        hresetn,     // Asynchronous reset, active low
  input  wire        hsel,        // Slave select
  input  wire [31:0] haddr,       // Byte address
  input  wire [1:0]  htrans,      // Transfer type
  input  wire        hwrite,      // Write strobe
  input  wire [2:0]  hsize,       // Transfer size
  input  wire [31:0] hwdata,      // Write data
  input  wire        hready,      // Bus ready in
  output wire [31:0] hrdata,      // Read data
  output wire        hreadyout,   // Always ready
  output wire        hresp,       // Always OKAY
  input  wire        slow_clk,    // Slow oscillator level, sampled
  input  wire        ref_osc_on,  // Reference oscillator running
  output wire [5:0]  trim_code,   // Trim to the slow oscillator
  output wire        irq          // Combined interrupt
);
  reg  [7:0]  status_reg;
  reg  [7:0]  control_reg;
  reg  [5:0]  floor_reg;
  reg  [5:0]  trim_reg;
  reg  [2:0]  slow_tgt_reg;
  reg  [12:0] ref_tgt_reg;
  reg  [2:0]  slow_cnt_reg;
  reg  [12:0] ref_cnt_reg;
  reg         running_reg;
  reg         slow_prev_reg;
  reg         ph_valid_reg;
  reg  [5:0]  ph_addr_reg;
  reg         ph_write_reg;
  reg  [31:0] rdata_reg;
  reg  [7:0]  status_next;
  reg  [7:0]  control_next;
  reg  [5:0]  trim_next;
  reg  [31:0] rdata_next;
  wire [5:0]  ceiling = `SOTC_RST_CEILING;
  wire        enable  = control_reg[`SOTC_BIT_ENABLE];
  wire        tolerance_select  = control_reg[`SOTC_BIT_TOLERANCE_SELECT];
  wire [13:0] tol     = tolerance_select ? `SOTC_TOL_WIDE : `SOTC_TOL_BASE;
  wire [13:0] hi_lim  = {1'b0, ref_tgt_reg} + tol;
  wire [13:0] meas    = {1'b0, ref_cnt_reg};
  wire        go_up   = meas > hi_lim;
  wire        go_down = ({1'b0, meas} + {1'b0, tol}) < {2'b00, ref_tgt_reg};
  wire        slow_rise = slow_clk & ~slow_prev_reg;
  wire        active  = enable & ref_osc_on & (slow_tgt_reg != 3'h0);
  wire        cyc_end = running_reg & active & slow_rise &
                        (slow_cnt_reg + 3'h1 == slow_tgt_reg);
  wire        addr_ok = hsel & htrans[1] & hready;
  wire        wr      = ph_valid_reg & ph_write_reg;
  wire        rd_sta  = ph_valid_reg & ~ph_write_reg & (ph_addr_reg == `SOTC_OFF_STATUS);
  wire        ovf     = running_reg & active & (ref_cnt_reg == 13'h1FFF);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign trim_code = trim_reg;
  assign irq = |(status_reg[3:0] & control_reg[3:0]);
  always @* begin
    // Clear only what the read returned, so a flag raised after the snapshot survives
    status_next  = rd_sta ? (status_reg & ~rdata_reg[7:0]) : status_reg;
    control_next = control_reg;
    trim_next    = trim_reg;
    if (wr && ph_addr_reg == `SOTC_OFF_CONTROL)
      control_next = hwdata[7:0];
    if (wr && ph_addr_reg == `SOTC_OFF_TRIM)
      trim_next = (hwdata[5:0] > ceiling) ? ceiling : hwdata[5:0];
    if (ovf)
      status_next[`SOTC_BIT_OVF] = 1'b1;
    if (cyc_end) begin
      status_next[`SOTC_BIT_CYCLE] = 1'b1;
      if (go_up) begin
        status_next[`SOTC_BIT_UP] = 1'b1;
        if (!control_reg[`SOTC_BIT_HOLD] && trim_reg < ceiling)
          trim_next = trim_reg + 6'h01;
      end else if (go_down) begin
        status_next[`SOTC_BIT_DOWN] = 1'b1;
        if (!control_reg[`SOTC_BIT_HOLD] && trim_reg > floor_reg)
          trim_next = trim_reg - 6'h01;
      end
      if (control_reg[`SOTC_BIT_AUTODIS])
        control_next[`SOTC_BIT_ENABLE] = 1'b0;
    end
    // Set wins over the read clear
    if (trim_next != trim_reg || cyc_end) begin
      if (trim_next == floor_reg)
        status_next[`SOTC_BIT_FLOOR] = 1'b1;
      if (trim_next == ceiling)
        status_next[`SOTC_BIT_CEIL] = 1'b1;
    end
  end
  always @* begin
    rdata_next = 32'h0000_0000;
    case (haddr[5:0])
      `SOTC_OFF_STATUS:   rdata_next[7:0]  = status_reg;
      `SOTC_OFF_CONTROL:  rdata_next[7:0]  = control_reg;
      `SOTC_OFF_CEILING:  rdata_next[5:0]  = ceiling;
      `SOTC_OFF_FLOOR:    rdata_next[5:0]  = floor_reg;
      `SOTC_OFF_TRIM:     rdata_next[5:0]  = trim_reg;
      `SOTC_OFF_SLOW_TGT: rdata_next[2:0]  = slow_tgt_reg;
      `SOTC_OFF_SLOW_CNT: rdata_next[2:0]  = slow_cnt_reg;
      `SOTC_OFF_REF_TGT:  rdata_next[12:0] = ref_tgt_reg;
      `SOTC_OFF_REF_CNT:  rdata_next[12:0] = ref_cnt_reg;
      default:            rdata_next = 32'h0000_0000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_addr_reg  <= 6'h00;
      ph_write_reg <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      ph_valid_reg <= addr_ok & (haddr[31:6] == 26'h0000000);
      ph_addr_reg  <= haddr[5:0];
      ph_write_reg <= hwrite;
      if (addr_ok && !hwrite)
        rdata_reg <= (haddr[31:6] == 26'h0000000) ? rdata_next : 32'h0000_0000;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg    <= `SOTC_RST_STATUS;
      control_reg   <= `SOTC_RST_CONTROL;
      floor_reg     <= `SOTC_RST_FLOOR;
      trim_reg      <= `SOTC_RST_TRIM;
      slow_tgt_reg  <= `SOTC_RST_SLOW_TGT;
      ref_tgt_reg   <= `SOTC_RST_REF_TGT;
      slow_cnt_reg  <= 3'h0;
      ref_cnt_reg   <= 13'h0000;
      running_reg   <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      status_reg    <= status_next;
      control_reg   <= control_next;
      trim_reg      <= trim_next;
      slow_prev_reg <= slow_clk;
      if (wr && ph_addr_reg == `SOTC_OFF_FLOOR)
        floor_reg <= hwdata[5:0];
      if (wr && ph_addr_reg == `SOTC_OFF_SLOW_TGT)
        slow_tgt_reg <= hwdata[2:0];
      if (wr && ph_addr_reg == `SOTC_OFF_REF_TGT)
        ref_tgt_reg <= hwdata[12:0];
      // Cycle opens on a slow edge so a full period is measured
      if (!active || cyc_end) begin
        running_reg <= 1'b0;
        if (!active)
          slow_cnt_reg <= 3'h0;
      end else if (!running_reg) begin
        if (slow_rise) begin
          running_reg  <= 1'b1;
          slow_cnt_reg <= 3'h0;
          ref_cnt_reg  <= 13'h0000;
        end
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 13'h0001;
        if (slow_rise)
          slow_cnt_reg <= slow_cnt_reg + 3'h1;
      end
    end
  end
endmodule // sotc_calibrator
`default_nettype wire

// *** testbench/sotc_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module sotc_chk (
  input wire        hclk,       // Clock
  input wire        hresetn,    // Reset, active low
  input wire        hsel,       // Select
  input wire [31:0] haddr,      // Address
  input wire [1:0]  htrans,     // Transfer type
  input wire        hwrite,     // Write
  input wire [31:0] hwdata,     // Write data
  input wire        hready,     // Ready in
  input wire [31:0] hrdata,     // Read data
  input wire        ref_osc_on, // Reference running
  input wire [5:0]  trim_code,  // Trim
  input wire        irq         // Interrupt
);
  reg       ph_q;
  reg       wr_q;
  reg [5:0] a_q;
  reg       hi_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= hsel & htrans[1] & hready;
    end
  end
  // Address kept for the data phase, reset not needed
  always @(posedge hclk) begin
    wr_q <= hwrite;
    a_q  <= haddr[5:0];
    hi_q <= |haddr[31:6];
  end
  wire rd    = ph_q & ~wr_q & ~hi_q;
  wire wtrim = ph_q & wr_q & ~hi_q & (a_q == 6'h10);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ceil_fixed_a: assert property (rd && a_q == 6'h08 |-> hrdata == 32'h3F)
    else $error("ceiling read not fixed value");
  floor_rw_a: assert property (ph_q && wr_q && a_q == 6'h0C ##2 rd && a_q == 6'h0C
    |-> hrdata[5:0] == $past(hwdata[5:0], 2)) else $error("floor readback wrong");
  stat_clear_a: assert property (rd && a_q == 6'h00 ##2 rd && a_q == 6'h00
    |-> hrdata == 32'h0) else $error("status not cleared by read");
  trim_step_a: assert property ($changed(trim_code) && !$past(wtrim)
    |-> trim_code == $past(trim_code) + 6'h01 || trim_code == $past(trim_code) - 6'h01)
    else $error("trim moved by more than one");
  osc_off_a: assert property (!ref_osc_on && !wtrim |=> $stable(trim_code))
    else $error("trim moved with reference off");
  trim_write_a: assert property (wtrim |=> trim_code == $past(hwdata[5:0]))
    else $error("trim write not applied");
  irq_mask_a: assert property (ph_q && wr_q && a_q == 6'h04 && hwdata[3:0] == 4'h0
    |=> !irq) else $error("interrupt with all enables off");
  cnt_width_a: assert property (rd && a_q == 6'h18 |-> hrdata[31:3] == 29'h0)
    else $error("slow count wider than field");
  cover property (wtrim);
  cover property ($rose(irq));
  cover property ($changed(trim_code) && !$past(wtrim));
endmodule // sotc_chk
bind sotc_calibrator sotc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .ref_osc_on, .trim_code, .irq);
`default_nettype wire

// *** testbench/sotc_calibrator_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sotc_defs.vh"
module sotc_calibrator_tb;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b1;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         slow_clk = 1'b0;
  reg         ref_osc_on = 1'b0;
  wire [31:0] hrdata;
  wire        hready;
  wire        hresp;
  wire [5:0]  trim_code;
  wire        irq;
  integer     failures = 0;
  integer     samples_checked = 0;
  integer     i;
  reg  [31:0] rv;
  sotc_calibrator dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .slow_clk, .ref_osc_on,
    .trim_code, .irq);
  initial forever #5 hclk = ~hclk;
  // Slow period of 100 reference cycles, so counts land near 100
  always begin
    repeat (50) @(posedge hclk);
    slow_clk <= ~slow_clk;
  end
  task tally_and_finish;
    begin
      $display("Compares %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [5:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {26'h0, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rv = hrdata;
    end
  endtask
  task rd(input [5:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rv, e);
    end
  endtask
  // One cycle with auto-disable, so flags cannot be set again behind our back
  task cal(input [7:0] c, input [12:0] t, input [5:0] v0, input [5:0] v1, input [7:0] s);
    begin
      xfer(1'b1, `SOTC_OFF_TRIM, {26'h0, v0});
      xfer(1'b1, `SOTC_OFF_REF_TGT, {19'h0, t});
      xfer(1'b0, `SOTC_OFF_STATUS, 32'h0);
      xfer(1'b1, `SOTC_OFF_CONTROL, {24'h0, c});
      for (i = 0; i < 400 && irq !== 1'b1; i = i + 1) @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      rd(`SOTC_OFF_TRIM, {26'h0, v1});
      rd(`SOTC_OFF_STATUS, {24'h0, s});
      rd(`SOTC_OFF_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SOTC_OFF_STATUS, 32'h0);
    rd(`SOTC_OFF_CONTROL, 32'h0);
    rd(`SOTC_OFF_CEILING, 32'h3F);
    rd(`SOTC_OFF_FLOOR, 32'h0);
    rd(`SOTC_OFF_TRIM, 32'h3F);
    rd(`SOTC_OFF_SLOW_TGT, 32'h0);
    rd(`SOTC_OFF_SLOW_CNT, 32'h0);
    rd(`SOTC_OFF_REF_TGT, 32'h0);
    rd(`SOTC_OFF_REF_CNT, 32'h0);
    xfer(1'b1, `SOTC_OFF_CONTROL, 32'h0);
    xfer(1'b1, `SOTC_OFF_CEILING, 32'h15);
    rd(`SOTC_OFF_CEILING, 32'h3F);
    xfer(1'b1, 6'h24, 32'hFF);
    rd(6'h24, 32'h0);
    xfer(1'b1, `SOTC_OFF_FLOOR, 32'h5);
    rd(`SOTC_OFF_FLOOR, 32'h5);
    xfer(1'b1, `SOTC_OFF_SLOW_TGT, 32'h1);
    ref_osc_on <= 1'b1;
    cal(8'h91, 13'd75, 6'h20, 6'h21, 8'h11);
    rd(`SOTC_OFF_CONTROL, 32'h81);
    cal(8'hB1, 13'd75, 6'h20, 6'h20, 8'h01);
    cal(8'h91, 13'd200, 6'h20, 6'h1F, 8'h21);
    cal(8'hD1, 13'd200, 6'h20, 6'h20, 8'h21);
    cal(8'h91, 13'd75, 6'h3E, 6'h3F, 8'h15);
    xfer(1'b1, `SOTC_OFF_FLOOR, 32'h20);
    cal(8'h91, 13'd200, 6'h21, 6'h20, 8'h29);
    cal(8'h91, 13'd200, 6'h20, 6'h20, 8'h29);
    tally_and_finish;
  end
endmodule // sotc_calibrator_tb
`default_nettype wire
